// ---- src/tsmc_map.vh ----
`ifndef TSMC_MAP_VH
`define TSMC_MAP_VH
// slave mode codes
`define TSMC_SM_OFF      3'h0
`define TSMC_SM_ENC1     3'h1
`define TSMC_SM_ENC2     3'h2
`define TSMC_SM_ENC3     3'h3
`define TSMC_SM_RESET    3'h4
`define TSMC_SM_GATED    3'h5
`define TSMC_SM_TRIGGER  3'h6
// trigger source codes
`define TSMC_TS_ITR0     3'h0
`define TSMC_TS_EDGE1    3'h4
`define TSMC_TS_FILT1    3'h5
`define TSMC_TS_FILT2    3'h6
`define TSMC_TS_EXTTRIG  3'h7
// capture select codes
`define TSMC_CS_OWN      2'h1
`define TSMC_CS_TRC      2'h3
// widths and reset values
`define TSMC_CNT_W       16
`define TSMC_OCMODE_W    12
`define TSMC_CHEN_W      4
`define TSMC_CNT_RST     16'h0000
`define TSMC_ARR_RST     16'hffff
`endif

// ---- src/tsmc_sync.v ----
`timescale 1ns/10ps
`default_nettype none
// two flip-flop synchroniser per bit
module tsmc_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             mclk,
  input  wire             resetn,
  // data
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // first stage only feeds second stage
  always @(posedge mclk) begin
    if (!resetn) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;
endmodule
`default_nettype wire

// ---- src/tsmc_top.v ----
// What this block does
// R1 - reset mode trigger clears counter, reloads, updates
// R2 - reset mode: restart from zero, set flag
// R3 - trigger mode 110 starts counter, sets flag
// R4 - gated mode 101 counts only while active
// R5 - gated mode flags both start and stop
// R6 - trigger inputs resynchronised before acting
// R7 - trigger select 101/110/100 picks inputs
// R8 - capture select 01 own input, polarity
// R9 - external clock mode 2 on trigger pin
// R10 - software avoids trigger source 111 then
// R11 - trigger plus ext clock counts pin edges
// R12 - commutation bits preloaded, copied on event
// R13 - preload only when preload control set
// R14 - commutation by software or trigger rise
// R15 - commutation sets flag, irq, dma request
// R16 - encoder codes 001, 010, 011 select edges
// R17 - encoder sets direction, wraps zero to reload
// R18 - input 1 edge direction table
// R19 - input 2 edge direction table
// R20 - software never mixes encoder and ext clock
// R21 - xor option combines three channel pins
// R22 - hall change restarts counter, capture interval
// R23 - two-stage synchroniser on external inputs
`timescale 1ns/10ps
`default_nettype none
`include "tsmc_map.vh"
module tsmc_top #(
  parameter CNT_W = `TSMC_CNT_W,
  parameter OCM_W = `TSMC_OCMODE_W,
  parameter CHN_W = `TSMC_CHEN_W
) (
  // clock and reset
  input  wire             mclk,
  input  wire             resetn,
  // external pins
  input  wire             channelPin1,
  input  wire             channelPin2,
  input  wire             channelPin3,
  input  wire             externalTriggerPin,
  input  wire             internalTrigger,
  // configuration
  input  wire [2:0]       slaveModeSelect,
  input  wire [2:0]       triggerSourceSelect,
  input  wire             counterEnableBit,
  input  wire             updateRequestSource,
  input  wire [1:0]       channel1CaptureSelect,
  input  wire [1:0]       channel2CaptureSelect,
  input  wire             channel1Polarity,
  input  wire             channel2Polarity,
  input  wire             extClockMode2Enable,
  input  wire             extTriggerPolarity,
  input  wire             xorSelect,
  input  wire [CNT_W-1:0] autoReload,
  // commutation control
  input  wire [OCM_W-1:0] outputCompareModePre,
  input  wire [CHN_W-1:0] channelOutputEnablePre,
  input  wire [CHN_W-1:0] complementaryOutputEnablePre,
  input  wire             comparePreloadControl,
  input  wire             commutationUpdateSelect,
  input  wire             commutationGenerate,
  input  wire             commutationIrqEnable,
  input  wire             commutationDmaEnable,
  input  wire             triggerFlagClear,
  input  wire             commutationFlagClear,
  // status and outputs
  output reg  [CNT_W-1:0] counterValue,
  output reg              countDown,
  output reg              counterRunning,
  output reg              triggerFlag,
  output reg              commutationFlag,
  output reg              commutationIrq,
  output reg              commutationDmaReq,
  output reg              updateEvent,
  output reg              reloadStrobe,
  output reg              captureStrobe,
  output reg  [CNT_W-1:0] captureValue,
  output reg  [OCM_W-1:0] outputCompareMode,
  output reg  [CHN_W-1:0] channelOutputEnable,
  output reg  [CHN_W-1:0] complementaryOutputEnable
);
  // synchronised pins
  wire [4:0] pinSync;
  wire       in1Raw;
  wire       in2Raw;
  wire       in3Raw;
  wire       extPinS;
  wire       itrS;

  tsmc_sync #(
    .WIDTH (5)
  ) uSync (
    .mclk    (mclk),
    .resetn  (resetn),
    .asyncIn ({internalTrigger, externalTriggerPin, channelPin3, channelPin2, channelPin1}),
    .syncOut (pinSync)
  ); // see R6, see R23

  assign in1Raw  = pinSync[0];
  assign in2Raw  = pinSync[1];
  assign in3Raw  = pinSync[2];
  assign extPinS = pinSync[3];
  assign itrS    = pinSync[4];

  // input 1 source, xor of three pins when selected
  wire timerInputOne;
  wire timerInputTwo;
  assign timerInputOne = xorSelect ? (in1Raw ^ in2Raw ^ in3Raw) : in1Raw; // see R21
  assign timerInputTwo = in2Raw;

  // polarity-adjusted filtered inputs
  wire filteredInput1;
  wire filteredInput2;
  wire filteredExtTrigger;
  assign filteredInput1     = timerInputOne ^ channel1Polarity; // see R8
  assign filteredInput2     = timerInputTwo ^ channel2Polarity; // see R8
  assign filteredExtTrigger = extPinS ^ extTriggerPolarity; // see R9

  // previous values for edge detection
  reg in1Prev_reg;
  reg fi1Prev_reg;
  reg fi2Prev_reg;
  reg extPrev_reg;
  reg trgPrev_reg;
  reg itrPrev_reg;

  // trigger source mux
  reg triggerInput;
  reg triggerEdge;
  always @* begin
    triggerInput = 1'b0;
    triggerEdge  = 1'b0;
    case (triggerSourceSelect)
      `TSMC_TS_EDGE1: begin
        triggerInput = timerInputOne;
        triggerEdge  = timerInputOne ^ in1Prev_reg; // see R7, see R22
      end
      `TSMC_TS_FILT1: begin
        triggerInput = filteredInput1;
        triggerEdge  = filteredInput1 & ~fi1Prev_reg; // see R7
      end
      `TSMC_TS_FILT2: begin
        triggerInput = filteredInput2;
        triggerEdge  = filteredInput2 & ~fi2Prev_reg; // see R7
      end
      `TSMC_TS_EXTTRIG: begin
        triggerInput = filteredExtTrigger;
        triggerEdge  = filteredExtTrigger & ~extPrev_reg;
      end
      `TSMC_TS_ITR0: begin
        triggerInput = itrS;
        triggerEdge  = itrS & ~itrPrev_reg;
      end
      default: begin
        triggerInput = 1'b0;
        triggerEdge  = 1'b0;
      end
    endcase
  end

  // mode decode
  wire encMode;
  wire resetMode;
  wire gatedMode;
  wire trigMode;
  wire enc1Mode;
  wire enc2Mode;
  assign enc1Mode  = (slaveModeSelect == `TSMC_SM_ENC1) || (slaveModeSelect == `TSMC_SM_ENC3);
  assign enc2Mode  = (slaveModeSelect == `TSMC_SM_ENC2) || (slaveModeSelect == `TSMC_SM_ENC3);
  assign encMode   = enc1Mode | enc2Mode; // see R16
  assign resetMode = (slaveModeSelect == `TSMC_SM_RESET);
  assign gatedMode = (slaveModeSelect == `TSMC_SM_GATED);
  assign trigMode  = (slaveModeSelect == `TSMC_SM_TRIGGER);

  // counter tick source: ext clock mode 2 pin edges or kernel clock
  wire extTick;
  wire countTick;
  assign extTick   = filteredExtTrigger & ~extPrev_reg; // see R9
  assign countTick = (extClockMode2Enable && !encMode) ? extTick : 1'b1; // see R11, see R20

  // encoder edges on filtered inputs
  wire fi1Rise;
  wire fi1Fall;
  wire fi2Rise;
  wire fi2Fall;
  assign fi1Rise = filteredInput1 & ~fi1Prev_reg;
  assign fi1Fall = ~filteredInput1 & fi1Prev_reg;
  assign fi2Rise = filteredInput2 & ~fi2Prev_reg;
  assign fi2Fall = ~filteredInput2 & fi2Prev_reg;

  // encoder step and direction
  reg encStep;
  reg encDown;
  always @* begin
    encStep = 1'b0;
    encDown = countDown;
    if (enc1Mode && (fi1Rise || fi1Fall)) begin
      encStep = 1'b1;
      encDown = fi1Rise ? filteredInput2 : ~filteredInput2; // see R18
    end else if (enc2Mode && (fi2Rise || fi2Fall)) begin
      encStep = 1'b1;
      encDown = fi2Rise ? ~filteredInput1 : filteredInput1; // see R19
    end
  end

  // next counter state
  reg [CNT_W-1:0] counter_next;
  reg             down_next;
  reg             running_next;
  reg             trigFlag_next;
  reg             update_next;
  reg             reload_next;
  reg             capture_next;
  wire            trigEnables;
  assign trigEnables = counterEnableBit | counterRunning;

  always @* begin
    counter_next  = counterValue;
    down_next     = countDown;
    running_next  = counterRunning;
    trigFlag_next = triggerFlag & ~triggerFlagClear;
    update_next   = 1'b0;
    reload_next   = 1'b0;
    capture_next  = 1'b0;
    if (!counterEnableBit) begin
      running_next = trigMode ? counterRunning : 1'b0;
    end
    if (encMode) begin
      running_next = counterEnableBit;
      if (counterEnableBit && encStep) begin
        down_next = encDown; // see R17
        if (encDown) begin
          counter_next = (counterValue == {CNT_W{1'b0}}) ? autoReload
                       : counterValue - {{(CNT_W-1){1'b0}}, 1'b1}; // see R17
        end else begin
          counter_next = (counterValue >= autoReload) ? {CNT_W{1'b0}}
                       : counterValue + {{(CNT_W-1){1'b0}}, 1'b1}; // see R17
        end
      end
    end else begin
      // up counter on selected tick
      if (counterRunning && countTick && (!gatedMode || triggerInput)) begin // see R4
        down_next    = 1'b0;
        counter_next = (counterValue >= autoReload) ? {CNT_W{1'b0}}
                     : counterValue + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (resetMode && triggerEdge) begin
        counter_next  = {CNT_W{1'b0}}; // see R1, see R2
        reload_next   = 1'b1; // see R1
        update_next   = ~updateRequestSource; // see R1
        trigFlag_next = 1'b1; // see R2
        capture_next  = (channel1CaptureSelect == `TSMC_CS_TRC); // see R22
        running_next  = counterEnableBit;
      end
      if (trigMode && triggerEdge) begin
        running_next  = 1'b1; // see R3, see R11
        trigFlag_next = 1'b1; // see R3, see R11
      end
      if (gatedMode && (triggerInput != trgPrev_reg) && counterEnableBit) begin
        trigFlag_next = 1'b1; // see R5
      end
      if (!trigMode && !resetMode) begin
        running_next = counterEnableBit;
      end
      if (resetMode && !triggerEdge) begin
        running_next = counterEnableBit;
      end
    end
    if (!trigEnables && !trigMode) begin
      running_next = 1'b0;
    end
  end

  // commutation event, software or trigger rising edge
  wire commutationEvent;
  wire trgRise;
  assign trgRise          = triggerInput & ~trgPrev_reg;
  assign commutationEvent = comparePreloadControl &
                            (commutationGenerate | (commutationUpdateSelect & trgRise)); // see R14

  // sequential state
  always @(posedge mclk) begin
    if (!resetn) begin
      // edge history follows its source in reset, so no false edge on release
      in1Prev_reg               <= timerInputOne;
      fi1Prev_reg               <= filteredInput1;
      fi2Prev_reg               <= filteredInput2;
      extPrev_reg               <= filteredExtTrigger;
      trgPrev_reg               <= triggerInput;
      itrPrev_reg               <= itrS;
      counterValue              <= `TSMC_CNT_RST;
      countDown                 <= 1'b0;
      counterRunning            <= 1'b0;
      triggerFlag               <= 1'b0;
      commutationFlag           <= 1'b0;
      commutationIrq            <= 1'b0;
      commutationDmaReq         <= 1'b0;
      updateEvent               <= 1'b0;
      reloadStrobe              <= 1'b0;
      captureStrobe             <= 1'b0;
      captureValue              <= `TSMC_CNT_RST;
      outputCompareMode         <= {OCM_W{1'b0}};
      channelOutputEnable       <= {CHN_W{1'b0}};
      complementaryOutputEnable <= {CHN_W{1'b0}};
    end else begin
      in1Prev_reg    <= timerInputOne;
      fi1Prev_reg    <= filteredInput1;
      fi2Prev_reg    <= filteredInput2;
      extPrev_reg    <= filteredExtTrigger;
      trgPrev_reg    <= triggerInput;
      itrPrev_reg    <= itrS;
      counterValue   <= counter_next;
      countDown      <= down_next;
      counterRunning <= running_next;
      triggerFlag    <= trigFlag_next; // set wins over clear
      updateEvent    <= update_next;
      reloadStrobe   <= reload_next;
      captureStrobe  <= capture_next;
      if (capture_next) begin
        captureValue <= counterValue; // see R22
      end
      // commutation flag, set wins over clear
      commutationFlag   <= commutationEvent | (commutationFlag & ~commutationFlagClear); // see R15
      commutationIrq    <= commutationEvent & commutationIrqEnable; // see R15
      commutationDmaReq <= commutationEvent & commutationDmaEnable; // see R15
      // shadow copy of preloaded bits
      if (commutationEvent) begin
        outputCompareMode         <= outputCompareModePre; // see R12, see R13
        channelOutputEnable       <= channelOutputEnablePre; // see R12
        complementaryOutputEnable <= complementaryOutputEnablePre; // see R12
      end else if (!comparePreloadControl) begin
        outputCompareMode         <= outputCompareModePre; // see R13
        channelOutputEnable       <= channelOutputEnablePre;
        complementaryOutputEnable <= complementaryOutputEnablePre;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/tsmc_pins.sv ----
`timescale 1ns/10ps
`default_nettype none
// pin-side model: encoder, hall sensor and trigger sources
module tsmc_pins (
  // clock
  input  wire logic mclk,
  // pins toward the timer
  output var  logic channelPin1,
  output var  logic channelPin2,
  output var  logic channelPin3,
  output var  logic externalTriggerPin
);
  logic [1:0] phase = 2'h0;
  // all pins low until a test moves them
  initial begin
    {externalTriggerPin, channelPin3, channelPin2, channelPin1} = 4'h0;
  end
  // set pins just after an edge, hold them n cycles
  task automatic put(input logic [3:0] v, input int n);
    {externalTriggerPin, channelPin3, channelPin2, channelPin1} = v;
    repeat (n) @(posedge mclk);
    #10;
  endtask
  // one gray-coded quadrature step, forward or back
  task automatic quad(input logic fwd, input int n);
    phase = fwd ? phase + 2'h1 : phase - 2'h1;
    put({externalTriggerPin, channelPin3, phase[1], phase[1] ^ phase[0]}, n);
  endtask
endmodule
`default_nettype wire

// ---- verif/tsmc_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
// timing checks on the controller ports
module tsmc_asserts (
  // clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // inputs
  input wire logic        channelPin1,
  input wire logic        channelPin2,
  input wire logic [2:0]  slaveModeSelect,
  input wire logic [2:0]  triggerSourceSelect,
  input wire logic        counterEnableBit,
  input wire logic        updateRequestSource,
  input wire logic        channel1Polarity,
  input wire logic        channel2Polarity,
  input wire logic        xorSelect,
  input wire logic [15:0] autoReload,
  input wire logic        comparePreloadControl,
  input wire logic        commutationGenerate,
  // outputs
  input wire logic [15:0] counterValue,
  input wire logic        countDown,
  input wire logic        counterRunning,
  input wire logic        triggerFlag,
  input wire logic        commutationFlag,
  input wire logic        updateEvent,
  input wire logic [11:0] outputCompareMode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // plain, uninverted channel inputs
  wire logic plain = !channel1Polarity && !channel2Polarity && !xorSelect;
  // slave mode and commutation relations
  a_reset_clears: assert property (
    slaveModeSelect == 3'h4 && triggerSourceSelect == 3'h5 && plain && counterEnableBit
    && $rose(channelPin1) |-> ##[2:4] (counterValue == '0 && triggerFlag))
    else $error("reset trigger lost");
  a_update_cause: assert property (
    updateEvent |-> slaveModeSelect == 3'h4 && !updateRequestSource && counterValue == '0)
    else $error("stray update");
  a_trig_start: assert property (
    slaveModeSelect == 3'h6 && triggerSourceSelect == 3'h6 && !channel2Polarity
    && $rose(channelPin2) |-> ##[2:4] (counterRunning && triggerFlag))
    else $error("trigger start lost");
  a_gate_hold: assert property (
    (slaveModeSelect == 3'h5 && triggerSourceSelect == 3'h5 && !xorSelect
    && channelPin1 == channel1Polarity) [*5] |=> $stable(counterValue))
    else $error("gated counter moved");
  a_shadow_hold: assert property (
    comparePreloadControl && $past(comparePreloadControl) && $changed(outputCompareMode)
    |-> commutationFlag) else $error("shadow changed without event");
  a_sw_commute: assert property (
    commutationGenerate && comparePreloadControl |-> ##[1:3] commutationFlag)
    else $error("commutation flag missing");
  a_enc_dir: assert property (
    slaveModeSelect == 3'h1 && plain && $rose(channelPin1) && !channelPin2
    |-> ##[2:4] (counterValue != $past(counterValue) && !countDown))
    else $error("encoder step wrong");
  a_enc_wrap: assert property (
    slaveModeSelect inside {3'h1, 3'h2, 3'h3} && $past(counterValue) <= autoReload
    |-> counterValue <= autoReload) else $error("encoder beyond reload");
endmodule
bind tsmc_top tsmc_asserts u_chk (
  .mclk(mclk), .resetn(resetn), .channelPin1(channelPin1), .channelPin2(channelPin2),
  .slaveModeSelect(slaveModeSelect), .triggerSourceSelect(triggerSourceSelect),
  .counterEnableBit(counterEnableBit), .updateRequestSource(updateRequestSource),
  .channel1Polarity(channel1Polarity), .channel2Polarity(channel2Polarity),
  .xorSelect(xorSelect), .autoReload(autoReload), .countDown(countDown),
  .comparePreloadControl(comparePreloadControl), .commutationGenerate(commutationGenerate),
  .counterValue(counterValue), .counterRunning(counterRunning), .triggerFlag(triggerFlag),
  .commutationFlag(commutationFlag), .updateEvent(updateEvent),
  .outputCompareMode(outputCompareMode)
);
`default_nettype wire

// ---- verif/tsmc_top_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the slave mode controller
module tsmc_top_bench;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  // control inputs
  logic        mclk = 1'b0, resetn = 1'b0, counter_enable_bit = 1'b0, urs = 1'b0, pol1 = 1'b0;
  logic        pol2 = 1'b0, eclk = 1'b0, epol = 1'b0, xsel = 1'b0, pre = 1'b0, cus = 1'b0;
  logic        cgen = 1'b0, irqEn = 1'b0, dmaEn = 1'b0, tclr = 1'b0, cclr = 1'b0;
  logic [2:0]  smode = 3'h0, trigger_source_select = 3'h0;
  logic [1:0]  cap1 = 2'h1;
  logic [15:0] arr = 16'hffff, v;
  logic [11:0] ocmPre = 12'h000;
  logic [3:0]  enPre = 4'h0, nenPre = 4'h0;
  // pins and outputs
  wire logic        p1, p2, p3, etp, dn, run, tflag, cflag, irq, dma, upd, capS, rld;
  wire logic [15:0] cnt, capV;
  wire logic [11:0] ocm;
  wire logic [3:0]  en, nen;
  int          error_cnt = 0, total_checks = 0, irqCnt = 0, dmaCnt = 0, capCnt = 0;
  int          rldCnt = 0;
  logic [15:0] expQ[$];

  // 10 MHz clock
  initial begin
    forever #50 mclk = ~mclk;
  end

  tsmc_pins u_pins (.mclk(mclk), .channelPin1(p1), .channelPin2(p2), .channelPin3(p3),
    .externalTriggerPin(etp));
  tsmc_top u_dut (.mclk(mclk), .resetn(resetn), .channelPin1(p1), .channelPin2(p2),
    .channelPin3(p3), .externalTriggerPin(etp), .internalTrigger(1'b0),
    .slaveModeSelect(smode), .triggerSourceSelect(trigger_source_select), .counterEnableBit(counter_enable_bit),
    .updateRequestSource(urs), .channel1CaptureSelect(cap1), .channel2CaptureSelect(2'h1),
    .channel1Polarity(pol1), .channel2Polarity(pol2), .extClockMode2Enable(eclk),
    .extTriggerPolarity(epol), .xorSelect(xsel), .autoReload(arr),
    .outputCompareModePre(ocmPre), .channelOutputEnablePre(enPre),
    .complementaryOutputEnablePre(nenPre), .comparePreloadControl(pre),
    .commutationUpdateSelect(cus), .commutationGenerate(cgen), .commutationIrqEnable(irqEn),
    .commutationDmaEnable(dmaEn), .triggerFlagClear(tclr), .commutationFlagClear(cclr),
    .counterValue(cnt), .countDown(dn), .counterRunning(run), .triggerFlag(tflag),
    .commutationFlag(cflag), .commutationIrq(irq), .commutationDmaReq(dma),
    .updateEvent(upd), .reloadStrobe(rld), .captureStrobe(capS), .captureValue(capV),
    .outputCompareMode(ocm), .channelOutputEnable(en), .complementaryOutputEnable(nen));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic restart();
    resetn = 1'b0;
    cyc(6);
    resetn = 1'b1;
    cyc(3);
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // match update pulses against noted values, count event pulses
  always @(posedge mclk) begin
    if (upd === 1'b1) begin
      if (expQ.size() == 0) check(ONE, ZERO);
      else check(32'(cnt), 32'(expQ.pop_front()));
    end
    if (irq === 1'b1) irqCnt++;
    if (dma === 1'b1) dmaCnt++;
    if (capS === 1'b1) capCnt++;
    if (rld === 1'b1) rldCnt++;
  end

  // cut the run if it hangs
  initial begin
    #3000000;
    error_cnt++;
    give_verdict();
  end

  // main sequence
  initial begin
    void'($urandom(32'hacfa));
    restart();
    // reset mode on channel 1, then with updates suppressed
    smode = 3'h4;
    trigger_source_select = 3'h5;
    counter_enable_bit = 1'b1;
    cyc(10);
    expQ.push_back(16'h0000);
    u_pins.put(4'h1, 1);
    check(32'(cnt != 16'h0000), ONE);
    cyc(5);
    check(32'(tflag && cnt < 16'h0006), ONE);
    urs = 1'b1;
    u_pins.put(4'h0, 4);
    u_pins.put(4'h1, 6);
    check(32'(cnt < 16'h0007), ONE);
    // trigger mode on channel 2
    u_pins.put(4'h0, 1);
    // configure before reset so no run state carries over
    smode = 3'h6;
    trigger_source_select = 3'h6;
    counter_enable_bit = 1'b0;
    restart();
    cyc(5);
    check(32'(run), ZERO);
    u_pins.put(4'h2, 6);
    check(32'(run && tflag), ONE);
    v = cnt;
    cyc(4);
    check(32'(cnt - v), 32'h0000_0004);
    // gated mode, channel 1 active low
    u_pins.put(4'h1, 1);
    restart();
    smode = 3'h5;
    trigger_source_select = 3'h5;
    pol1 = 1'b1;
    counter_enable_bit = 1'b1;
    cyc(8);
    check(32'(cnt), ZERO);
    u_pins.put(4'h0, 6);
    check(32'(tflag && run), ONE);
    pulse(tclr);
    u_pins.put(4'h1, 6);
    check(32'(tflag), ONE);
    v = cnt;
    cyc(5);
    check(32'(cnt), 32'(v));
    pol1 = 1'b0;
    // trigger mode counting external pin edges
    u_pins.put(4'h0, 1);
    // configure before reset so the counter waits for the trigger
    smode = 3'h6;
    trigger_source_select = 3'h5;
    eclk = 1'b1;
    restart();
    u_pins.put(4'h8, 3);
    u_pins.put(4'h0, 3);
    check(32'(cnt), ZERO);
    u_pins.put(4'h1, 6);
    repeat (4) begin
      u_pins.put(4'h9, 3);
      u_pins.put(4'h1, 3);
    end
    check(32'(cnt), 32'h0000_0004);
    eclk = 1'b0;
    // commutation by software, by trigger edge, then preload off
    u_pins.put(4'h0, 1);
    restart();
    smode = 3'h0;
    pre = 1'b1;
    irqEn = 1'b1;
    dmaEn = 1'b1;
    {nenPre, enPre, ocmPre} = 20'($urandom);
    cyc(3);
    check(32'({nen, en, ocm}), ZERO);
    pulse(cgen);
    cyc(3);
    check(32'({nen, en, ocm}), 32'({nenPre, enPre, ocmPre}));
    pulse(cclr);
    irqEn = 1'b0;
    cus = 1'b1;
    {nenPre, enPre, ocmPre} = 20'($urandom);
    u_pins.put(4'h1, 6);
    check(32'({cflag, nen, en, ocm}), 32'({1'b1, nenPre, enPre, ocmPre}));
    check(32'({irqCnt[7:0], dmaCnt[7:0]}), 32'h0000_0102);
    pulse(cclr);
    pre = 1'b0;
    {nenPre, enPre, ocmPre} = 20'($urandom);
    pulse(cgen);
    cyc(3);
    check(32'({cflag, nen, en, ocm}), 32'({1'b0, nenPre, enPre, ocmPre}));
    // hall sensor through the xor path
    u_pins.put(4'h0, 1);
    restart();
    smode = 3'h4;
    trigger_source_select = 3'h4;
    cap1 = 2'h3;
    xsel = 1'b1;
    urs = 1'b0;
    cyc(10);
    expQ.push_back(16'h0000);
    u_pins.put(4'h4, 10);
    expQ.push_back(16'h0000);
    u_pins.put(4'h0, 10);
    check(32'({capCnt[7:0], 7'h00, capV != 16'h0000}), 32'h0000_0201);
    xsel = 1'b0;
    cap1 = 2'h1;
    // encoder modes: three turns forward, one back
    for (int m = 1; m < 4; m++) begin
      smode = 3'(m);
      arr = 16'h0003 + 16'($urandom % 8);
      restart();
      for (int k = 0; k < 16; k++) u_pins.quad(k < 12, 5);
      check(32'(cnt), 32'((m == 3 ? 8 : 4) % (int'(arr) + 1)));
      check(32'(dn), ONE);
    end
    check(32'(expQ.size()), ZERO);
    check(32'(rldCnt), 32'h0000_0004);
    give_verdict();
  end
endmodule
`default_nettype wire
